// [logic/isc_consts.svh]
/*
  Constants of the interrupt signaling channel endpoint: command codes,
  register offsets, field positions and sizes.
  Assumes it is included by bare name from files under logic/.
*/
`ifndef ISC_CONSTS_SVH
`define ISC_CONSTS_SVH

// upstream command codes (from the interrupt source)
`define ISC_UP_RESET       3'h0
`define ISC_UP_INT         3'h1
`define ISC_UP_RSACK       3'h2
`define ISC_UP_QUIESCE     3'h3
`define ISC_UP_FLUSHACK    3'h4
`define ISC_UP_IMPDEF      3'h7

// downstream command codes (to the interrupt source)
`define ISC_DN_RESETACK    3'h0
`define ISC_DN_RESAMPLE    3'h2
`define ISC_DN_QACK        3'h3
`define ISC_DN_FLUSH       3'h4

// register byte offsets
`define ISC_ADDR_CTRL      8'h00
`define ISC_ADDR_STATUS    8'h04
`define ISC_LEVEL_PAGE     3'h1
`define ISC_PAGE_MSB       7
`define ISC_PAGE_LSB       5
`define ISC_WORD_MSB       4
`define ISC_WORD_LSB       2

// control register fields
`define ISC_CTRL_GO        0
`define ISC_CTRL_IDV       1
`define ISC_CTRL_CLRREF    2
`define ISC_CTRL_ID_LSB    8
`define ISC_CTRL_ID_MSB    15

// status register fields
`define ISC_ST_ONLINE      0
`define ISC_ST_RSPEND      1
`define ISC_ST_FLPEND      2
`define ISC_ST_FLSENT      3
`define ISC_ST_REFUSED     4
`define ISC_ST_STATE_LSB   8
`define ISC_ST_STATE_MSB   10

// level memory shape
`define ISC_LEVEL_WORDS    8
`define ISC_IDX_MSB        7
`define ISC_IDX_LSB        5
`define ISC_BIT_MSB        4

`endif

// [logic/isc_pkg.sv]
/*
  Types shared by the interrupt signaling channel endpoint.
  Assumes nothing of its surroundings.
*/
package isc_pkg;

  typedef enum logic [2:0] {
    ISC_OFFLINE     = 3'b000,
    ISC_FLUSH_SEND  = 3'b001,
    ISC_FLUSH_WAIT  = 3'b010,
    ISC_RSTACK_SEND = 3'b011,
    ISC_ONLINE      = 3'b100,
    ISC_DRAIN       = 3'b101
  } isc_state_e;

  typedef logic [2:0] isc_cmd_t;
  typedef logic [7:0] isc_intid_t;

endpackage

// [logic/isc_up_decode.sv]
/*
  Upstream command classifier: one strobe per known command.
  Assumes command fields are valid only while upValid is high.
*/
`timescale 1ns/1ps
`include "isc_consts.svh"

module isc_up_decode (
  // command in
  input  wire logic              upValid,
  input  wire isc_pkg::isc_cmd_t upCmd,
  // strobes out
  output wire logic              isReset,
  output wire logic              isInt,
  output wire logic              isRsAck,
  output wire logic              isQuiesce,
  output wire logic              isFlushAck,
  output wire logic              isDiscard
);

  assign isReset    = upValid & (upCmd == `ISC_UP_RESET);
  assign isInt      = upValid & (upCmd == `ISC_UP_INT);
  assign isRsAck    = upValid & (upCmd == `ISC_UP_RSACK);
  assign isQuiesce  = upValid & (upCmd == `ISC_UP_QUIESCE);
  assign isFlushAck = upValid & (upCmd == `ISC_UP_FLUSHACK);
  // implementation-defined and reserved codes raise only the discard strobe
  assign isDiscard  = upValid & ~(isReset | isInt | isRsAck | isQuiesce | isFlushAck);

endmodule

// [logic/isc_level_mem.sv]
/*
  Level memory: one bit per interrupt, 8 words of 32, with single-bit
  writes, a one-cycle clear of every word and a registered word read.
  Assumes clrAll and wrEn come from the same clock domain.
*/
`timescale 1ns/1ps
`include "isc_consts.svh"

module isc_level_mem (
  // system
  input  wire logic        clk,
  input  wire logic        rst_n,
  // write side
  input  wire logic        clrAll,
  input  wire logic        wrEn,
  input  wire logic [7:0]  wrIdx,
  input  wire logic        wrBit,
  // read side
  input  wire logic [2:0]  rdWord,
  output logic      [31:0] rdData
);

  wire  [31:0] bitMask = 32'h1 << wrIdx[`ISC_BIT_MSB:0];
  wire  [31:0] viewWord [`ISC_LEVEL_WORDS];

  genvar g;
  for (g = 0; g < `ISC_LEVEL_WORDS; g++) begin : g_word
    logic        live;
    logic [31:0] word;
    wire         hit  = wrEn & (wrIdx[`ISC_IDX_MSB:`ISC_IDX_LSB] == 3'(g));
    wire  [31:0] base = live ? word : 32'h0;
    // a dead word reads as zero, so a clear costs one cycle for all words
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        live <= 1'h0;
        word <= 32'h0;
      end else if (clrAll) begin
        live <= 1'h0;
      end else if (hit) begin
        live <= 1'h1;
        word <= (base & ~bitMask) | (wrBit ? bitMask : 32'h0);
      end
    end
    assign viewWord[g] = base;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= 32'h0;
    end else begin
      rdData <= viewWord[rdWord];
    end
  end

endmodule

// [logic/isc_channel.sv]
/*
  Routing-service end of an interrupt signaling channel: takes upstream
  commands, keeps per-interrupt levels, runs reset, flush, quiesce and
  resample exchanges and offers a classic Wishbone register slave.
  Assumes one upstream command per cycle when upValid is high, a
  downstream valid/ready handshake, and a single 40 MHz clock.
*/
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "isc_consts.svh"

// Operation
// - service sends reset ack 0, resample 2, quiesce ack 3, flush 4, 7.
// - code 7 commands never change other commands; unsupported ones are dropped.
// - neither side sends code 7 without agreed meaning.
// - reset-ack, resample-ack-or-reset, quiesce-ack, flush-ack pair with their commands.
// - every acknowledgement arrives within bounded time.
// - at most one resample and one flush outstanding per channel.
// - edge/level: 00 down, 01 up, 10 pulse, 11 rising and held.
// - service may resample one interrupt or all interrupts.
// - unreported interrupts after whole resample count as deasserted.
// - reset order: reset, flush, flush ack, reset ack.
// - service sends at most one flush per channel reset.
// - after quiesce: finish outstanding, no resample, then quiesce ack, offline.
module isc_channel (
  // system
  input  wire logic                clk,
  input  wire logic                rst_n,
  // wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // upstream commands
  input  wire logic                upValid,
  input  wire isc_pkg::isc_cmd_t   upCmd,
  input  wire isc_pkg::isc_intid_t upIntId,
  input  wire logic                upEdge,
  input  wire logic                upLevel,
  // downstream commands
  output logic                     dnValid,
  output isc_pkg::isc_cmd_t        dnCmd,
  output logic                     dnIdValid,
  output isc_pkg::isc_intid_t      dnIntId,
  input  wire logic                dnReady,
  // events and state
  output logic                     edgeEvent,
  output isc_pkg::isc_intid_t      edgeEventId,
  output logic                     online
);

  isc_pkg::isc_state_e st;
  isc_pkg::isc_state_e next_st;
  logic                resamplePending;
  logic                flushPending;
  logic                flushSent;
  logic                rsRefused;
  logic                ctrlIdv;
  isc_pkg::isc_intid_t ctrlId;
  logic                busAct;
  logic [31:0]         memRdata;
  logic [31:0]         statusWord;
  logic [31:0]         ctrlWord;
  logic                isReset;
  logic                isInt;
  logic                isRsAck;
  logic                isQuiesce;
  logic                isFlushAck;
  logic                isDiscard;
  isc_pkg::isc_cmd_t   dnNextCmd;

  isc_up_decode i_isc_up_decode (
    .upValid    (upValid),
    .upCmd      (upCmd),
    .isReset    (isReset),
    .isInt      (isInt),
    .isRsAck    (isRsAck),
    .isQuiesce  (isQuiesce),
    .isFlushAck (isFlushAck),
    .isDiscard  (isDiscard)
  );

  // bus decode
  wire busStart  = wb_cyc_i & wb_stb_i & ~busAct & ~wb_ack_o;
  // a write lands on the edge at which the master samples ack high
  wire busWrite  = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i;
  wire selCtrl   = (wb_adr_i == `ISC_ADDR_CTRL);
  wire selStatus = (wb_adr_i == `ISC_ADDR_STATUS);
  wire selLevel  = (wb_adr_i[`ISC_PAGE_MSB:`ISC_PAGE_LSB] == `ISC_LEVEL_PAGE);
  wire ctrlWr0   = busWrite & selCtrl & wb_sel_i[0];
  wire ctrlWr1   = busWrite & selCtrl & wb_sel_i[1];
  wire goReq     = ctrlWr0 & wb_dat_i[`ISC_CTRL_GO];
  wire clrRefReq = ctrlWr0 & wb_dat_i[`ISC_CTRL_CLRREF];
  wire rsIdvNow  = ctrlWr0 ? wb_dat_i[`ISC_CTRL_IDV] : ctrlIdv;
  wire [7:0] rsIdNow = ctrlWr1 ? wb_dat_i[`ISC_CTRL_ID_MSB:`ISC_CTRL_ID_LSB] : ctrlId;
  wire [2:0] rdWord  = wb_adr_i[`ISC_WORD_MSB:`ISC_WORD_LSB];

  always_comb begin
    ctrlWord = 32'h0;
    ctrlWord[`ISC_CTRL_IDV] = ctrlIdv;
    ctrlWord[`ISC_CTRL_ID_MSB:`ISC_CTRL_ID_LSB] = ctrlId;
  end

  always_comb begin
    statusWord = 32'h0;
    statusWord[`ISC_ST_ONLINE]  = online;
    statusWord[`ISC_ST_RSPEND]  = resamplePending;
    statusWord[`ISC_ST_FLPEND]  = flushPending;
    statusWord[`ISC_ST_FLSENT]  = flushSent;
    statusWord[`ISC_ST_REFUSED] = rsRefused;
    statusWord[`ISC_ST_STATE_MSB:`ISC_ST_STATE_LSB] = st;
  end

  wire [31:0] readMux = selCtrl   ? ctrlWord   :
                        selStatus ? statusWord :
                        selLevel  ? memRdata   : 32'h0;

  // downstream loads; the slot is free only when nothing waits on the link
  wire inDrain    = (st == isc_pkg::ISC_DRAIN);
  wire dnFree     = ~dnValid & ~isReset;
  wire flushLoad  = dnFree & (st == isc_pkg::ISC_FLUSH_SEND) & ~isFlushAck & ~flushSent;
  wire rstAckLoad = dnFree & (st == isc_pkg::ISC_RSTACK_SEND);
  wire qackLoad   = dnFree & inDrain & ~resamplePending & ~flushPending;
  wire rsAllowed  = dnFree & (st == isc_pkg::ISC_ONLINE) & ~resamplePending & ~isQuiesce;
  wire rsLoad     = goReq & rsAllowed;
  wire rsDenied   = goReq & ~rsAllowed;
  wire anyLoad    = flushLoad | rstAckLoad | qackLoad | rsLoad;
  // levels drop on reset, on going offline and when a whole resample starts
  wire memClr     = isReset | qackLoad | (rsLoad & ~rsIdvNow);
  wire intTake    = isInt & ((st == isc_pkg::ISC_ONLINE) | inDrain);

  // only the four defined codes ever leave; code 7 is never generated
  assign dnNextCmd = flushLoad  ? `ISC_DN_FLUSH    :
                     rstAckLoad ? `ISC_DN_RESETACK :
                     qackLoad   ? `ISC_DN_QACK     : `ISC_DN_RESAMPLE;

  isc_level_mem i_isc_level_mem (
    .clk    (clk),
    .rst_n  (rst_n),
    .clrAll (memClr),
    .wrEn   (intTake),
    .wrIdx  (upIntId),
    .wrBit  (upLevel),
    .rdWord (rdWord),
    .rdData (memRdata)
  );

  always_comb begin
    next_st = st;
    case (st)
      isc_pkg::ISC_OFFLINE: begin
        next_st = st;
      end
      isc_pkg::ISC_FLUSH_SEND: begin
        // an early flush ack makes the flush needless
        if (isFlushAck) begin
          next_st = isc_pkg::ISC_RSTACK_SEND;
        end else if (flushLoad) begin
          next_st = isc_pkg::ISC_FLUSH_WAIT;
        end
      end
      isc_pkg::ISC_FLUSH_WAIT: begin
        if (!flushPending) begin
          next_st = isc_pkg::ISC_RSTACK_SEND;
        end
      end
      isc_pkg::ISC_RSTACK_SEND: begin
        if (rstAckLoad) begin
          next_st = isc_pkg::ISC_ONLINE;
        end
      end
      isc_pkg::ISC_ONLINE: begin
        if (isQuiesce) begin
          next_st = isc_pkg::ISC_DRAIN;
        end
      end
      isc_pkg::ISC_DRAIN: begin
        if (qackLoad) begin
          next_st = isc_pkg::ISC_OFFLINE;
        end
      end
      default: begin
        next_st = isc_pkg::ISC_OFFLINE;
      end
    endcase
    // a flush still outstanding from an earlier reset is not sent again
    if (isReset) begin
      next_st = flushPending ? isc_pkg::ISC_FLUSH_WAIT : isc_pkg::ISC_FLUSH_SEND;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st     <= isc_pkg::ISC_OFFLINE;
      online <= 1'h0;
    end else begin
      st     <= next_st;
      online <= (next_st == isc_pkg::ISC_ONLINE) | (next_st == isc_pkg::ISC_DRAIN);
    end
  end

  // outstanding commands; the set side wins over the clear side, except flushSent, where the reset clear wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resamplePending <= 1'h0;
      flushPending    <= 1'h0;
      flushSent       <= 1'h0;
    end else begin
      if (rsLoad) begin
        resamplePending <= 1'h1;
      end else if (isRsAck | isReset) begin
        resamplePending <= 1'h0;
      end
      if (flushLoad) begin
        flushPending <= 1'h1;
      end else if (isFlushAck) begin
        flushPending <= 1'h0;
      end
      if (isReset) begin
        flushSent <= 1'h0;
      end else if (flushLoad) begin
        flushSent <= 1'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dnValid   <= 1'h0;
      dnCmd     <= `ISC_DN_RESETACK;
      dnIdValid <= 1'h0;
      dnIntId   <= 8'h0;
    end else if (anyLoad) begin
      dnValid   <= 1'h1;
      dnCmd     <= dnNextCmd;
      dnIdValid <= rsLoad & rsIdvNow;
      dnIntId   <= rsLoad ? rsIdNow : 8'h0;
    end else if (dnValid & dnReady) begin
      dnValid   <= 1'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edgeEvent   <= 1'h0;
      edgeEventId <= 8'h0;
    end else begin
      edgeEvent   <= intTake & upEdge;
      edgeEventId <= upIntId;
    end
  end

  // register slave
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busAct   <= 1'h0;
      wb_ack_o <= 1'h0;
      wb_dat_o <= 32'h0;
    end else begin
      if (busStart) begin
        busAct <= 1'h1;
      end else if (wb_ack_o) begin
        busAct <= 1'h0;
      end
      wb_ack_o <= busAct & ~wb_ack_o;
      if (busAct & ~wb_ack_o) begin
        wb_dat_o <= readMux;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlIdv   <= 1'h0;
      ctrlId    <= 8'h0;
      rsRefused <= 1'h0;
    end else begin
      if (ctrlWr0) begin
        ctrlIdv <= wb_dat_i[`ISC_CTRL_IDV];
      end
      if (ctrlWr1) begin
        ctrlId <= wb_dat_i[`ISC_CTRL_ID_MSB:`ISC_CTRL_ID_LSB];
      end
      if (rsDenied) begin
        rsRefused <= 1'h1;
      end else if (clrRefReq) begin
        rsRefused <= 1'h0;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence rsIssue;
    rsLoad && !resamplePending;
  endsequence
  sequence rsOnLink;
    dnValid && dnCmd == `ISC_DN_RESAMPLE && resamplePending;
  endsequence
  sequence resetIn;
    isReset;
  endsequence
  sequence resetFlow;
    st == isc_pkg::ISC_FLUSH_SEND || st == isc_pkg::ISC_FLUSH_WAIT;
  endsequence

  dn_code_legal_a: assert property (
    dnValid |-> dnCmd inside {`ISC_DN_RESETACK, `ISC_DN_RESAMPLE, `ISC_DN_QACK, `ISC_DN_FLUSH})
    else $error("illegal downstream code");
  rs_single_a: assert property (
    rsLoad |-> rsIssue ##1 rsOnLink)
    else $error("second resample issued while one outstanding");
  flush_once_a: assert property (
    flushLoad |-> !flushSent && !flushPending ##1 (flushSent && dnCmd == `ISC_DN_FLUSH))
    else $error("flush sent twice in one reset");
  reset_order_a: assert property (
    resetIn |=> resetFlow)
    else $error("reset did not enter flush phase");
  rstack_gate_a: assert property (
    rstAckLoad |-> !flushPending && !isReset)
    else $error("reset ack before flush acknowledged");
  discard_quiet_a: assert property (
    isDiscard && !anyLoad && !goReq && !(st == isc_pkg::ISC_FLUSH_WAIT && !flushPending)
      |=> $stable(st) && $stable(resamplePending) && $stable(flushPending) && !edgeEvent)
    else $error("discarded command changed state");
  quiesce_nors_a: assert property (
    inDrain |-> !rsLoad && !($rose(dnValid) && dnCmd == `ISC_DN_RESAMPLE))
    else $error("resample sent after quiesce");
  qack_bound_a: assert property (
    inDrain && !dnValid && !resamplePending && !flushPending && !isReset
      |=> dnValid && dnCmd == `ISC_DN_QACK && st == isc_pkg::ISC_OFFLINE)
    else $error("quiesce ack not given when drained");
  rs_pair_a: assert property (
    (isRsAck || isReset) && !rsLoad |=> !resamplePending)
    else $error("resample not closed by its ack");
  whole_clear_a: assert property (
    rsLoad && !rsIdvNow |-> memClr ##1 (dnValid && !dnIdValid))
    else $error("whole resample without level clear");
  edge_event_a: assert property (
    intTake && upEdge |=> edgeEvent && edgeEventId == $past(upIntId))
    else $error("edge report lost");
  bus_ack_a: assert property (
    busStart |=> !wb_ack_o ##1 wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer timing wrong");

endmodule

// [tb/isc_source_model.sv]
/*
  Interrupt source model: drives upstream commands, stalls and answers the
  downstream ones. Assumes send is called right after a rising clock edge.
*/
`timescale 1ns/1ps

module isc_source_model (
  // system
  input  wire logic                clk,
  input  wire logic                rst_n,
  // downstream
  input  wire logic                dnValid,
  input  wire isc_pkg::isc_cmd_t   dnCmd,
  input  wire logic                dnIdValid,
  input  wire isc_pkg::isc_intid_t dnIntId,
  output logic                     dnReady,
  // upstream
  output logic                     upValid,
  output isc_pkg::isc_cmd_t        upCmd,
  output isc_pkg::isc_intid_t      upIntId,
  output logic                     upEdge,
  output logic                     upLevel
);
  logic                lvl [256];
  logic                rsPend;
  logic                rsAll;
  isc_pkg::isc_intid_t rsId;

  initial begin
    upValid = 1'b0;
    upCmd = 3'h5;
    upIntId = 8'h5a;
    upEdge = 1'b0;
    upLevel = 1'b1;
    rsPend = 1'b0;
    rsAll = 1'b0;
    rsId = 8'h00;
    foreach (lvl[i]) lvl[i] = 1'b0;
  end

  // random stalls on the downstream side
  always @(posedge clk) dnReady <= 1'($urandom);

  // one command, then idle fields inverted so stale values never match
  task automatic send(input isc_pkg::isc_cmd_t c, input isc_pkg::isc_intid_t id,
                      input logic e, input logic l);
    upValid <= 1'b1;
    upCmd <= c;
    upIntId <= id;
    upEdge <= e;
    upLevel <= l;
    if (c == 3'h1) lvl[id] = l;
    if (c == 3'h0) begin
      foreach (lvl[i]) lvl[i] = 1'b0;
      rsPend = 1'b0;
    end
    @(posedge clk);
    upValid <= 1'b0;
    upCmd <= ~c;
    upIntId <= ~id;
    upEdge <= ~e;
    upLevel <= ~l;
    @(posedge clk);
  endtask

  // slow resample answer: reports of asserted interrupts, then the ack
  task automatic reply();
    repeat (20) @(posedge clk);
    if (rsPend) begin
      for (int i = 0; i < 256; i++)
        if (lvl[i] && (rsAll || rsId == 8'(i))) send(3'h1, 8'(i), 1'b0, 1'b1);
      send(3'h2, 8'h00, 1'b0, 1'b0);
      rsPend = 1'b0;
    end
  endtask

  initial forever begin
    @(posedge clk);
    if (rst_n && dnValid && dnReady) begin
      if (dnCmd == 3'h4) send(3'h4, 8'h00, 1'b0, 1'b0);
      if (dnCmd == 3'h2) begin
        rsPend = 1'b1;
        rsAll = !dnIdValid;
        rsId = dnIntId;
        fork
          reply();
        join_none
      end
    end
  end
endmodule

// [tb/interrupt_signaling_channel_bench.sv]
/*
  Self-checking bench of the channel endpoint: Wishbone master tasks,
  expectation queues and a watcher. Assumes the source model beside it.
*/
`timescale 1ns/1ps

module interrupt_signaling_channel_bench;
  logic                clk;
  logic                rst_n;
  logic                wb_cyc_i;
  logic                wb_stb_i;
  logic                wb_we_i;
  logic [7:0]          wb_adr_i;
  logic [3:0]          wb_sel_i;
  logic [31:0]         wb_dat_i;
  logic [31:0]         wb_dat_o;
  logic                wb_ack_o;
  logic                upValid;
  isc_pkg::isc_cmd_t   upCmd;
  isc_pkg::isc_intid_t upIntId;
  logic                upEdge;
  logic                upLevel;
  logic                dnValid;
  isc_pkg::isc_cmd_t   dnCmd;
  logic                dnIdValid;
  isc_pkg::isc_intid_t dnIntId;
  logic                dnReady;
  logic                edgeEvent;
  isc_pkg::isc_intid_t edgeEventId;
  logic                online;
  logic [11:0]         dnQ [$];
  logic [63:0]         rdQ [$];
  logic [7:0]          evQ [$];
  logic [63:0]         rdE;
  logic [11:0]         dnE;
  logic [7:0]          ids [4];
  int                  errCount;
  int                  nChecks;

  isc_channel i_isc_channel (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .upValid(upValid),
    .upCmd(upCmd), .upIntId(upIntId), .upEdge(upEdge), .upLevel(upLevel),
    .dnValid(dnValid), .dnCmd(dnCmd), .dnIdValid(dnIdValid), .dnIntId(dnIntId),
    .dnReady(dnReady), .edgeEvent(edgeEvent), .edgeEventId(edgeEventId), .online(online));

  isc_source_model i_isc_source_model (.clk(clk), .rst_n(rst_n), .dnValid(dnValid),
    .dnCmd(dnCmd), .dnIdValid(dnIdValid), .dnIntId(dnIntId), .dnReady(dnReady),
    .upValid(upValid), .upCmd(upCmd), .upIntId(upIntId), .upEdge(upEdge),
    .upLevel(upLevel));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic fail();
    errCount++;
    summarize();
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errCount++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // watcher: every result that appears takes the oldest note
  always @(posedge clk) begin
    if (rst_n && dnValid && dnReady) begin
      dnE = (dnQ.size() > 0) ? dnQ.pop_front() : 12'hfff;
      check({20'h0, dnCmd, dnIdValid, dnIntId}, {20'h0, dnE});
      if (dnE[11:9] == 3'h0 || dnE[11:9] == 3'h3)
        check({31'h0, online}, {31'h0, dnE[11:9] == 3'h0});
    end
    if (wb_ack_o && !wb_we_i) begin
      rdE = rdQ.pop_front();
      check(wb_dat_o & rdE[63:32], rdE[31:0]);
    end
    if (edgeEvent && evQ.size() == 0) check({24'h0, edgeEventId}, 32'hffffffff);
    else if (edgeEvent) check({24'h0, edgeEventId}, {24'h0, evQ.pop_front()});
  end

  task automatic wbReq(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) fail();
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
    rdQ.push_back({mask, exp & mask});
    wbReq(1'b0, a, 32'h0);
  endtask

  task automatic lvlRd(input logic [7:0] id, input logic b);
    rd(8'h20 + {id[7:5], 2'b00}, 32'(b) << id[4:0], 32'h1 << id[4:0]);
  endtask

  task automatic waitQ(input int n);
    int k;
    k = 0;
    while ((dnQ.size() > n || i_isc_source_model.rsPend) && k < 400) begin
      @(posedge clk);
      k++;
    end
    if (k >= 400) fail();
  endtask

  initial begin
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    errCount = 0;
    nChecks = 0;
    void'($urandom(32'h8525));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(8'h04, 32'h0, 32'h717);
    rd(8'h10, 32'h0, 32'hffffffff);
    $display("test 1 done");
    dnQ.push_back({3'h4, 1'b0, 8'h00});
    dnQ.push_back({3'h0, 1'b0, 8'h00});
    i_isc_source_model.send(3'h0, 8'h00, 1'b0, 1'b0);
    waitQ(0);
    rd(8'h04, 32'h401, 32'h717);
    $display("test 2 done");
    ids = '{8'h00, 8'(1 + $urandom % 127), 8'(128 + $urandom % 127), 8'hff};
    for (int k = 0; k < 4; k++) begin
      if (k[1]) evQ.push_back(ids[k]);
      i_isc_source_model.send(3'h1, ids[k], k[1], k[0]);
      lvlRd(ids[k], k[0]);
    end
    $display("test 3 done");
    for (int c = 5; c < 8; c++) i_isc_source_model.send(3'(c), 8'hff, 1'b0, 1'b0);
    lvlRd(8'hff, 1'b1);
    rd(8'h04, 32'h401, 32'h717);
    $display("test 4 done");
    i_isc_source_model.lvl[255] = 1'b0;
    dnQ.push_back({3'h2, 1'b0, 8'h00});
    wbReq(1'b1, 8'h00, 32'h1);
    wbReq(1'b1, 8'h00, 32'h1);
    rd(8'h04, 32'h413, 32'h717);
    waitQ(0);
    lvlRd(8'hff, 1'b0);
    lvlRd(ids[1], 1'b1);
    wbReq(1'b1, 8'h00, 32'h4);
    rd(8'h04, 32'h401, 32'h717);
    $display("test 5 done");
    dnQ.push_back({3'h2, 1'b1, ids[1]});
    wbReq(1'b1, 8'h00, {16'h0, ids[1], 8'h03});
    waitQ(0);
    lvlRd(ids[1], 1'b1);
    $display("test 6 done");
    dnQ.push_back({3'h2, 1'b1, ids[1]});
    dnQ.push_back({3'h4, 1'b0, 8'h00});
    dnQ.push_back({3'h0, 1'b0, 8'h00});
    wbReq(1'b1, 8'h00, {16'h0, ids[1], 8'h03});
    for (int k = 0; k < 400 && dnQ.size() > 2; k++) @(posedge clk);
    if (dnQ.size() > 2) fail();
    i_isc_source_model.send(3'h0, 8'h00, 1'b0, 1'b0);
    waitQ(0);
    lvlRd(ids[1], 1'b0);
    rd(8'h04, 32'h401, 32'h717);
    $display("test 7 done");
    dnQ.push_back({3'h2, 1'b0, 8'h00});
    dnQ.push_back({3'h3, 1'b0, 8'h00});
    wbReq(1'b1, 8'h00, 32'h1);
    waitQ(1);
    i_isc_source_model.send(3'h3, 8'h00, 1'b0, 1'b0);
    wbReq(1'b1, 8'h00, 32'h1);
    waitQ(0);
    rd(8'h04, 32'h010, 32'h717);
    $display("test 8 done");
    summarize();
  end
endmodule
